//--- include/tstc_defs.vh
// tstc_defs.vh: register offsets, field positions and reset values of the
// slave-mode / trigger-control block. definitions only.
`ifndef TSTC_DEFS_VH
`define TSTC_DEFS_VH
`define TSTC_SMCR_OFF 12'h008
`define TSTC_DIER_OFF 12'h00c
`define TSTC_SMCR_RST 32'h0000_0000
`define TSTC_DIER_RST 32'h0000_0000
`define TSTC_SMCR_MASK 32'h0000_fff7
`define TSTC_DIER_MASK 32'h0000_5f5f
`define TSTC_SMS_LSB 0
`define TSTC_TS_LSB 4
`define TSTC_MSM_BIT 7
`define TSTC_ETF_LSB 8
`define TSTC_ETPS_LSB 12
`define TSTC_ECE_BIT 14
`define TSTC_ETP_BIT 15
`define TSTC_UIE_BIT 0
`define TSTC_CCIE_LSB 1
`define TSTC_TIE_BIT 6
`define TSTC_UDE_BIT 8
`define TSTC_CCDE_LSB 9
`define TSTC_TDE_BIT 14
`define TSTC_SMS_OFF 3'h0
`define TSTC_SMS_QD0 3'h1
`define TSTC_SMS_QD1 3'h2
`define TSTC_SMS_QD2 3'h3
`define TSTC_SMS_RESTART 3'h4
`define TSTC_SMS_PAUSE 3'h5
`define TSTC_SMS_EVENT 3'h6
`define TSTC_SMS_EXTCLK 3'h7
`define TSTC_TS_EXT_TRIG_FILTERED 3'h7
`define TSTC_DTS_DIV 4'h2
`endif

//--- rtl/tstc_top.v
// tstc_top.v: trigger selection, external trigger prescaler and filter,
// slave mode controller and dma/interrupt enable gating of a timer.
// assumes an apb master on clock, counter core and channels outside; pins
// and other timers' triggers are asynchronous and synchronised here.
// Behaviour
// - external trigger filter changes output after N equal samples; code 0 is N=1
// - codes 1..3 sample at kernel clock N=2,4,8; higher codes divided dead-time clock
// - sync start bit makes selected trigger the start event for chained timers
// - trigger select 0..3 picks internal triggers 0..3
// - select 4..7 picks ch1 edge, ch1 filtered, ch2 filtered, external trigger
// - slave mode 0: counter clocked by kernel clock while enable bit set
// - mode 1 counts on ch2 edges, direction from ch1 level
// - mode 2 counts on ch1 edges, direction from ch2 level
// - mode 3 counts on both edges, direction from the other input
// - mode 4 rising trigger restarts counter and reloads shadow registers
// - mode 5 counter clock runs while trigger high, stops while low
// - mode 6 rising trigger starts counter, never stopped by slave logic
// - mode 7 counter steps on each rising trigger edge
// - trigger dma enable bit 14 gates trigger dma request
// - bits 12..9 gate channel 4..1 capture/compare dma requests
// - update dma enable bit 8 gates update dma request
// - bit 6 gates trigger interrupt, bits 4..1 gate channel interrupts
// - with both external clock modes on, filtered external trigger clocks counter
// - trigger event on rising edge while slave mode is not 0, on both edges in pause mode
// - bit 0 gates update interrupt
`timescale 1ns/1ns
`default_nettype none
`include "tstc_defs.vh"
module tstc_top #(
   parameter DTS_DIV = 2
)(
   input wire clock,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [3:0] internal_trigger,
   input wire ch1_edge_detect,
   input wire ch1_filtered_input,
   input wire ch2_filtered_input,
   input wire ext_trig_pin,
   input wire counter_enable_bit,
   input wire update_event,
   input wire [3:0] cc_event,
   output reg count_step,
   output reg count_down,
   output reg counter_restart,
   output reg counter_start,
   output reg trigger_event,
   output reg trigger_input,
   output reg ext_trig_filtered,
   output reg update_irq,
   output reg trig_irq,
   output reg [3:0] cc_irq,
   output reg update_dma_req,
   output reg trig_dma_req,
   output reg [3:0] cc_dma_req
);

   // filter length for a code; kernel-rate codes first
   function [3:0] flt_len;
      input [3:0] code;
      begin
         case (code)
            4'h0: flt_len = 4'h1;
            4'h1: flt_len = 4'h2;
            4'h2: flt_len = 4'h4;
            4'h3: flt_len = 4'h8;
            4'h4, 4'h6, 4'h8, 4'he: flt_len = 4'h6;
            4'h9, 4'ha: flt_len = 4'h5;
            default: flt_len = 4'h8;
         endcase
      end
   endfunction

   // log2 of the dead-time divider applied per code
   function [2:0] flt_shift;
      input [3:0] code;
      begin
         case (code)
            4'h4, 4'h5: flt_shift = 3'h1;
            4'h6, 4'h7: flt_shift = 3'h2;
            4'h8, 4'h9: flt_shift = 3'h3;
            4'ha, 4'hb, 4'hc, 4'hd: flt_shift = 3'h4;
            4'he, 4'hf: flt_shift = 3'h5;
            default: flt_shift = 3'h0;
         endcase
      end
   endfunction

   // reset release and pin synchronisers, two flops each; only s2 copies are read
   reg rst_s1_q;
   reg rst_s2_q;
   reg [7:0] in_s1_q;
   reg [7:0] in_s2_q;
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
         in_s1_q <= 8'h00;
         in_s2_q <= 8'h00;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
         in_s1_q <= {ext_trig_pin, ch2_filtered_input, ch1_filtered_input, ch1_edge_detect, internal_trigger};
         in_s2_q <= in_s1_q;
      end
   end
   wire rst_n = rst_s2_q;

   // registers
   reg [31:0] smcr_q;
   reg [31:0] dier_q;
   wire [2:0] slave_mode_select = smcr_q[`TSTC_SMS_LSB+2:`TSTC_SMS_LSB];
   wire [2:0] trigger_select = smcr_q[`TSTC_TS_LSB+2:`TSTC_TS_LSB];
   wire sync_start_enable = smcr_q[`TSTC_MSM_BIT];
   wire [3:0] ext_trig_filter = smcr_q[`TSTC_ETF_LSB+3:`TSTC_ETF_LSB];
   wire [1:0] ext_trig_psc = smcr_q[`TSTC_ETPS_LSB+1:`TSTC_ETPS_LSB];
   wire ext_clock2_enable = smcr_q[`TSTC_ECE_BIT];
   wire ext_trig_pol = smcr_q[`TSTC_ETP_BIT];

   // apb slave: one wait state, unmapped addresses answer slverr
   wire acc = psel && penable && !pready;
   wire hit_smcr = (paddr == `TSTC_SMCR_OFF);
   wire hit_dier = (paddr == `TSTC_DIER_OFF);
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smcr_q <= `TSTC_SMCR_RST;
         dier_q <= `TSTC_DIER_RST;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= acc;
         pslverr <= acc && !hit_smcr && !hit_dier;
         if (acc && pwrite && hit_smcr)
            smcr_q <= pwdata & `TSTC_SMCR_MASK; // reserved bit 3 held at zero
         if (acc && pwrite && hit_dier)
            dier_q <= pwdata & `TSTC_DIER_MASK;
         if (acc && !pwrite)
            prdata <= hit_smcr ? smcr_q : (hit_dier ? dier_q : 32'h0000_0000);
         else
            prdata <= 32'h0000_0000;
      end
   end

   wire ch1_f = in_s2_q[5];
   wire ch2_f = in_s2_q[6];
   wire etr_pol = in_s2_q[7] ^ ext_trig_pol;

   // external trigger prescaler: divides active edges by 1,2,4,8
   reg etr_last_q;
   reg [2:0] psc_cnt_q;
   wire etr_rise = etr_pol && !etr_last_q;
   wire [2:0] psc_top = (3'h1 << (ext_trig_psc - 2'h1)) - 3'h1; // two toggles make one output period
   reg ext_trig_prescaled;
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         etr_last_q <= 1'b0;
         psc_cnt_q <= 3'h0;
         ext_trig_prescaled <= 1'b0;
      end
      else
      begin
         etr_last_q <= etr_pol;
         if (ext_trig_psc == 2'h0)
            ext_trig_prescaled <= etr_pol;
         else if (etr_rise)
         begin
            if (psc_cnt_q >= psc_top)
            begin
               psc_cnt_q <= 3'h0;
               ext_trig_prescaled <= ~ext_trig_prescaled;
            end
            else
               psc_cnt_q <= psc_cnt_q + 3'h1;
         end
      end
   end

   // dead-time clock enable and its further division for sampling
   reg [3:0] dts_cnt_q;
   reg [4:0] smp_cnt_q;
   wire dts_tick = (dts_cnt_q == 4'h0);
   wire [4:0] smp_mask = (5'h1 << flt_shift(ext_trig_filter)) - 5'h1;
   wire kern_rate = (ext_trig_filter != 4'h0) && (ext_trig_filter < 4'h4);
   wire smp_en = kern_rate ? 1'b1 : (dts_tick && ((smp_cnt_q & smp_mask) == 5'h0));
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dts_cnt_q <= 4'h0;
         smp_cnt_q <= 5'h0;
      end
      else
      begin
         dts_cnt_q <= (dts_cnt_q >= DTS_DIV[3:0] - 4'h1) ? 4'h0 : dts_cnt_q + 4'h1;
         if (dts_tick)
            smp_cnt_q <= smp_cnt_q + 5'h1;
      end
   end

   // digital filter: output follows input after N equal samples
   reg [3:0] flt_cnt_q;
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flt_cnt_q <= 4'h0;
         ext_trig_filtered <= 1'b0;
      end
      else if (smp_en)
      begin
         if (ext_trig_prescaled == ext_trig_filtered)
            flt_cnt_q <= 4'h0;
         else if (flt_cnt_q + 4'h1 >= flt_len(ext_trig_filter))
         begin
            ext_trig_filtered <= ext_trig_prescaled;
            flt_cnt_q <= 4'h0;
         end
         else
            flt_cnt_q <= flt_cnt_q + 4'h1;
      end
   end

   // trigger source multiplexer
   reg trg_sel;
   always @*
   begin
      case (trigger_select)
         3'h0, 3'h1, 3'h2, 3'h3: trg_sel = in_s2_q[trigger_select[1:0]];
         3'h4: trg_sel = in_s2_q[4];
         3'h5: trg_sel = ch1_f;
         3'h6: trg_sel = ch2_f;
         default: trg_sel = ext_trig_filtered;
      endcase
   end

   // edge history; reselecting the trigger is legal only with slave mode off, so no glitch filter
   reg trg_last_q;
   reg ch1_last_q;
   reg ch2_last_q;
   reg ext_trig_filtered_last_q;
   reg started_q;
   wire trg_rise = trg_sel && !trg_last_q;
   wire trg_edge = trg_sel ^ trg_last_q;
   wire ch1_edge = ch1_f ^ ch1_last_q;
   wire ch2_edge = ch2_f ^ ch2_last_q;
   wire ext_trig_filtered_rise = ext_trig_filtered && !ext_trig_filtered_last_q;
   wire sm_on = (slave_mode_select != `TSTC_SMS_OFF);

   // slave mode controller
   reg step_d;
   reg down_d;
   reg trig_d;
   always @*
   begin
      step_d = 1'b0;
      down_d = count_down;
      trig_d = sm_on && trg_rise;
      case (slave_mode_select)
         `TSTC_SMS_OFF: step_d = counter_enable_bit;
         `TSTC_SMS_QD0:
         begin
            step_d = ch2_edge;
            down_d = ch2_edge ? (ch1_f ^ ch2_f) : count_down;
         end
         `TSTC_SMS_QD1:
         begin
            step_d = ch1_edge;
            down_d = ch1_edge ? ~(ch1_f ^ ch2_f) : count_down;
         end
         `TSTC_SMS_QD2:
         begin
            step_d = ch1_edge || ch2_edge;
            down_d = ch1_edge ? ~(ch1_f ^ ch2_f) : (ch2_edge ? (ch1_f ^ ch2_f) : count_down);
         end
         `TSTC_SMS_PAUSE:
         begin
            step_d = trg_sel;
            trig_d = trg_edge;
         end
         `TSTC_SMS_EXTCLK: step_d = trg_rise;
         default: step_d = counter_enable_bit || started_q;
      endcase
      if (ext_clock2_enable)
         step_d = ext_trig_filtered_rise; // external clock 2 wins
   end

   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trg_last_q <= 1'b0;
         ch1_last_q <= 1'b0;
         ch2_last_q <= 1'b0;
         ext_trig_filtered_last_q <= 1'b0;
         started_q <= 1'b0;
         count_step <= 1'b0;
         count_down <= 1'b0;
         counter_restart <= 1'b0;
         counter_start <= 1'b0;
         trigger_event <= 1'b0;
         trigger_input <= 1'b0;
      end
      else
      begin
         trg_last_q <= trg_sel;
         ch1_last_q <= ch1_f;
         ch2_last_q <= ch2_f;
         ext_trig_filtered_last_q <= ext_trig_filtered;
         // event mode latches run; only leaving the mode clears it
         if (slave_mode_select != `TSTC_SMS_EVENT)
            started_q <= 1'b0;
         else if (trg_rise)
            started_q <= 1'b1;
         count_step <= step_d;
         count_down <= down_d;
         counter_restart <= (slave_mode_select == `TSTC_SMS_RESTART) && trg_rise;
         // start pulse lets chained timers begin together
         counter_start <= trg_rise && ((slave_mode_select == `TSTC_SMS_EVENT) || sync_start_enable);
         trigger_event <= trig_d;
         trigger_input <= trg_sel;
      end
   end

   // dma and interrupt gating; the enable enters directly so a clear masks the next cycle's output
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         update_irq <= 1'b0;
         trig_irq <= 1'b0;
         cc_irq <= 4'h0;
         update_dma_req <= 1'b0;
         trig_dma_req <= 1'b0;
         cc_dma_req <= 4'h0;
      end
      else
      begin
         update_irq <= update_event && dier_q[`TSTC_UIE_BIT];
         trig_irq <= trig_d && dier_q[`TSTC_TIE_BIT];
         cc_irq <= cc_event & dier_q[`TSTC_CCIE_LSB+3:`TSTC_CCIE_LSB];
         update_dma_req <= update_event && dier_q[`TSTC_UDE_BIT];
         trig_dma_req <= trig_d && dier_q[`TSTC_TDE_BIT];
         cc_dma_req <= cc_event & dier_q[`TSTC_CCDE_LSB+3:`TSTC_CCDE_LSB];
      end
   end

endmodule
`default_nettype wire

//--- sim/tstc_chk.sv
// checker for tstc_top: bus answer timing and gated event outputs
// bound to tstc_top; sees its ports only
`timescale 1ns/1ns
`default_nettype none
module tstc_chk (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic update_event,
   input wire logic [3:0] cc_event,
   input wire logic update_irq,
   input wire logic update_dma_req,
   input wire logic [3:0] cc_irq,
   input wire logic [3:0] cc_dma_req,
   input wire logic counter_restart,
   input wire logic counter_start
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // every update and channel gated output traces back to its event one cycle before
   a_upd_irq_cause: assert property (update_irq |-> $past(update_event))
      else $error("update irq without event");
   a_upd_dma_cause: assert property (update_dma_req |-> $past(update_event))
      else $error("update dma without event");
   a_cc_irq_cause: assert property ((cc_irq & ~$past(cc_event)) == 4'h0)
      else $error("channel irq without event");
   a_cc_dma_cause: assert property ((cc_dma_req & ~$past(cc_event)) == 4'h0)
      else $error("channel dma without event");
   // a restart or start pulse lasts a single cycle
   a_restart_pulse: assert property (counter_restart |=> !counter_restart)
      else $error("restart longer than one cycle");
   a_start_pulse: assert property (counter_start |=> !counter_start)
      else $error("start longer than one cycle");
   // one wait state, then a single ready cycle
   a_ready_answer: assert property ((psel && penable && !pready) |=> pready)
      else $error("no ready after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   cover property (counter_restart);
   cover property (pslverr);
   cover property (|cc_irq);
endmodule
bind tstc_top tstc_chk chk (.clock, .nrst, .psel, .penable, .pready, .pslverr, .update_event, .cc_event,
   .update_irq, .update_dma_req, .cc_irq, .cc_dma_req, .counter_restart, .counter_start);
`default_nettype wire

//--- sim/tstc_enc.sv
// quadrature encoder model standing on the two channel inputs
// assumes the bench holds run for whole multiples of eight clocks
`timescale 1ns/1ns
`default_nettype none
module tstc_enc (
   input wire logic clock,
   input wire logic run,
   input wire logic dir,
   input wire logic load,
   input wire logic [1:0] load_val,
   output logic ch1,
   output logic ch2
);
   logic [2:0] div_q = 3'h0;
   logic [1:0] ph_q = 2'h0; // {ch1,ch2}: forward walks 00,10,11,01
   // one phase change per eight clocks keeps levels well past the synchronisers
   always @(posedge clock)
   begin
      div_q <= div_q + 3'h1;
      if (load)
         ph_q <= load_val;
      else if (run && div_q == 3'h7)
         ph_q <= dir ? {ph_q[0], ~ph_q[1]} : {~ph_q[0], ph_q[1]};
   end
   assign ch1 = ph_q[1];
   assign ch2 = ph_q[0];
endmodule
`default_nettype wire

//--- sim/tb_timer_slave_trigger_control.sv
// bench for tstc_top: apb registers, event gating, trigger select, slave modes
// assumes tstc_chk is bound in and tstc_enc drives the channel inputs
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module tb_timer_slave_trigger_control;
   localparam logic [11:0] SMCR = 12'h008;
   localparam logic [11:0] DIER = 12'h00c;
   logic clock = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [3:0] internal_trigger = 4'h0, cc_event = 4'h0;
   logic ch1_edge_detect = 1'h0, ext_trig_pin = 1'h0, counter_enable_bit = 1'h0, update_event = 1'h0;
   logic run = 1'h0, dir = 1'h0, load = 1'h0;
   logic [1:0] load_val = 2'h0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, ch1_filtered_input, ch2_filtered_input, count_step, count_down, counter_restart;
   wire logic counter_start, trigger_event, trigger_input, update_irq, trig_irq, update_dma_req, trig_dma_req;
   wire logic [3:0] cc_irq, cc_dma_req;
   wire logic ext_trig_filtered;
   int n_errors = 0, checks_done = 0, n_step = 0, n_rst = 0, n_start = 0, n_evt = 0, n_ti = 0;
   tstc_top #(.DTS_DIV(1)) dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .internal_trigger, .ch1_edge_detect, .ch1_filtered_input, .ch2_filtered_input, .ext_trig_pin,
      .counter_enable_bit, .update_event, .cc_event, .count_step, .count_down, .counter_restart, .counter_start,
      .trigger_event, .trigger_input, .ext_trig_filtered, .update_irq, .trig_irq, .cc_irq, .update_dma_req,
      .trig_dma_req, .cc_dma_req);
   tstc_enc enc (.clock, .run, .dir, .load, .load_val, .ch1(ch1_filtered_input), .ch2(ch2_filtered_input));
   always #20 clock = ~clock;
   // cycle tallies of pulses and levels, cleared by clr
   always @(posedge clock)
   begin
      n_step += count_step;
      n_rst += counter_restart;
      n_start += counter_start;
      n_evt += trigger_event;
      n_ti += trig_irq + trig_dma_req;
   end
   task automatic test_done(input bit hung);
      if (hung)
         n_errors++;
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic clr();
      @(negedge clock);
      {n_step, n_rst, n_start, n_evt, n_ti} = '0;
      // back on the rising edge so the next stimulus lands there
      @(posedge clock);
   endtask
   // one transfer; the request stands until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      while (pready !== 1'h1)
      begin
         @(posedge clock);
         i++;
         if (i > 20)
            test_done(1'h1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // trigger sources: itr 3..0, ch1 edge, ch1, ch2, external pin
   task automatic srcs(input logic [7:0] s);
      internal_trigger <= s[3:0];
      ch1_edge_detect <= s[4];
      load <= 1'h1;
      load_val <= {s[5], s[6]};
      ext_trig_pin <= s[7];
      @(posedge clock);
      load <= 1'h0;
   endtask
   // exp is {update irq, channel irqs, update dma, channel dmas}
   task automatic gate(input logic [31:0] en, input logic [9:0] exp);
      apb(1'h1, DIER, en);
      update_event <= 1'h1;
      cc_event <= 4'hf;
      @(posedge clock);
      update_event <= 1'h0;
      cc_event <= 4'h0;
      @(negedge clock);
      `CHK("gated outputs", exp, {update_irq, cc_irq, update_dma_req, cc_dma_req})
   endtask
   initial
   begin
      cyc(3);
      nrst <= 1'h1;
      cyc(3);
      apb(1'h0, DIER, 32'h0);
      `CHK("enable reset", 32'h0, rd)
      apb(1'h1, DIER, 32'hffff_ffff);
      apb(1'h0, DIER, 32'h0);
      `CHK("enable bits", 32'h0000_5f5f, rd)
      apb(1'h1, SMCR, 32'hffff_fff7);
      apb(1'h0, SMCR, 32'h0);
      `CHK("config bits", 32'h0000_fff7, rd)
      apb(1'h1, SMCR, 32'h0);
      apb(1'h0, 12'h040, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd})
      gate(32'h0000_140b, 10'h2aa);
      gate(32'h0000_4140, 10'h010);
      gate(32'h0, 10'h000);
      for (int t = 0; t < 8; t++)
      begin
         apb(1'h1, SMCR, 32'(t) << 4);
         srcs(8'h00);
         cyc(12);
         `CHK("trigger idle", 1'h0, trigger_input)
         srcs(8'h01 << t);
         cyc(12);
         `CHK("trigger chosen", 1'h1, trigger_input)
      end
      srcs(8'h00);
      apb(1'h1, SMCR, 32'h0);
      counter_enable_bit <= 1'h1;
      cyc(4);
      `CHK("kernel step", 1'h1, count_step)
      counter_enable_bit <= 1'h0;
      apb(1'h1, DIER, 32'h0000_4040);
      `CHK("kernel stop", 1'h0, count_step)
      for (int m = 4; m < 8; m++)
      begin
         apb(1'h1, SMCR, 32'(m) | ((m == 4) ? 32'h80 : 32'h0));
         clr();
         repeat (3)
         begin
            srcs(8'h01);
            cyc(5);
            srcs(8'h00);
            cyc(5);
         end
         cyc(6);
         `CHK("restarts", (m == 4) ? 3 : 0, n_rst)
         `CHK("starts", (m == 4 || m == 6) ? 3 : 0, n_start)
         `CHK("trig events", (m == 5) ? 6 : 3, n_evt)
         `CHK("trig irq dma", (m == 5) ? 12 : 6, n_ti)
         if (m == 6)
            `CHK("event run", 1'h1, count_step)
         else if (m != 4)
            `CHK("steps", (m == 5) ? 18 : 3, n_step)
      end
      for (int m = 1; m < 4; m++)
      begin
         apb(1'h1, SMCR, 32'(m));
         clr();
         dir <= m[0];
         run <= 1'h1;
         cyc(64);
         run <= 1'h0;
         cyc(8);
         `CHK("quad steps", (m == 3) ? 8 : 4, n_step)
         `CHK("quad dir", m[0], count_down)
      end
      // external clock 2 on the filtered pin: a six-sample pulse passes only unfiltered
      for (int f = 0; f < 4; f += 3)
      begin
         apb(1'h1, SMCR, 32'h0000_4000 | (32'(f) << 8));
         clr();
         srcs(8'h80);
         cyc(5);
         srcs(8'h00);
         cyc(12);
         srcs(8'h80);
         cyc(12);
         `CHK("etr filtered", 1'h1, ext_trig_filtered)
         srcs(8'h00);
         cyc(12);
         `CHK("etr clock steps", (f == 0) ? 2 : 1, n_step)
      end
      test_done(1'h0);
   end
endmodule
`default_nettype wire
